/* sws_map.svh */
// Offsets, field positions, reset values and timing counts of the service window supervisor
// Assumes inclusion by bare name from every design file that needs them
`ifndef SWS_MAP_SVH
`define SWS_MAP_SVH

// ==========================================================
// Register map
`define SWS_SVR_OFFSET    8'hC7
`define SWS_WIN_HI        7
`define SWS_WIN_LO        6
`define SWS_KEY_HI        5
`define SWS_KEY_LO        1
`define SWS_CM_BIT        0
`define SWS_KEY_VALUE     5'h0C
`define SWS_WIN_RESET     2'h3
`define SWS_CM_RESET      1'b1

// ==========================================================
// Timing
`define SWS_SYS_PERIOD_NS 10
`define SWS_INSTR_NS      1000
`define SWS_INSTR_DIV     (`SWS_INSTR_NS / `SWS_SYS_PERIOD_NS)
`define SWS_LOWER_LIMIT   17'h00800
`define SWS_UPPER_BASE    17'h02000
`define SWS_RELEASE_CYC   17
`define SWS_CM_LIMIT_NS   100000
`define SWS_CM_LIMIT_CYC  ((`SWS_CM_LIMIT_NS + `SWS_SYS_PERIOD_NS - 1) / `SWS_SYS_PERIOD_NS)

`endif

/* sws_pkg.sv */
// Types shared by the service window supervisor
// Assumes nothing beyond a SystemVerilog compiler
package sws_pkg;

  // ==========================================================
  // Fault sequencer states
  typedef enum logic [1:0] {
    SWS_RUN   = 2'b00,
    SWS_PULL  = 2'b01,
    SWS_HOLD  = 2'b10,
    SWS_REARM = 2'b11
  } sws_state_e;

  typedef logic [1:0]  sws_win_t;
  typedef logic [16:0] sws_count_t;

endpackage

/* sws_release_timer.sv */
// Release delay counter: counts instruction ticks while run is held
// Assumes tick is a one-cycle enable on the same clock
`timescale 1ns/100ps

module sws_release_timer #(
  parameter int COUNT = 17
) (
  input  wire logic clk_in,    // System clock
  input  wire logic rst_n_in,  // Async reset, active low
  input  wire logic run_in,    // Count while high, clear when low
  input  wire logic tick_in,   // Instruction cycle enable
  output logic      done_out   // High once COUNT ticks seen
);

  localparam int W = $clog2(COUNT + 1);

  logic [W-1:0] cnt_r;

  // ==========================================================
  // Counter
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
    end else if (!run_in) begin
      cnt_r <= '0;
    end else if (tick_in && (cnt_r != W'(COUNT))) begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  assign done_out = run_in && (cnt_r == W'(COUNT));

endmodule

/* sws_top.sv */
// Service window supervisor: keyed service timer and clock-frequency monitor
// Assumes all inputs synchronous to SYS_CLK_IN; fault pin wire resolved outside
`timescale 1ns/100ps
`include "sws_map.svh"

module sws_top #(
  parameter int INSTR_DIV    = `SWS_INSTR_DIV,
  parameter int CM_LIMIT_CYC = `SWS_CM_LIMIT_CYC,
  parameter int RELEASE_CYC  = `SWS_RELEASE_CYC
) (
  input  wire logic       SYS_CLK_IN,                      // 100 MHz clock
  input  wire logic       RESETN_IN,                       // Async reset, active low
  input  wire logic [7:0] REG_ADDR_IN,                     // Data memory address
  input  wire logic       REG_WR_IN,                       // Write strobe
  input  wire logic       REG_RD_IN,                       // Read strobe
  input  wire logic [7:0] REG_WDATA_IN,                    // Write data
  output logic      [7:0] REG_RDATA_OUT,                   // Read data
  input  wire logic       HALT_MODE_IN,                    // Halt mode level
  input  wire logic       IDLE_MODE_IN,                    // Idle mode level
  input  wire logic       XTAL_OPTION_IN,                  // Crystal oscillator option
  input  wire logic       CLOCK_DELAY_SELECT_IN,           // Clock-delay bit
  input  wire logic       CLOCK_INPUT_PIN_IN,              // Monitored clock input pin
  input  wire logic       SUPERVISION_FAULT_PIN_IN,        // Sensed fault pin level
  output logic            SUPERVISION_FAULT_PIN_OUT,       // Fault pin drive value
  output logic            SUPERVISION_FAULT_PIN_OE_N_OUT   // Fault pin enable, active low
);

  localparam int DW  = $clog2(INSTR_DIV);
  localparam int CMW = $clog2(CM_LIMIT_CYC + 1);

  // ==========================================================
  // Declarations
  sws_pkg::sws_state_e st_r;
  sws_pkg::sws_state_e st_nxt;
  sws_pkg::sws_win_t   win_sel_r;
  sws_pkg::sws_count_t cnt_r;
  sws_pkg::sws_count_t cnt_nxt;
  sws_pkg::sws_count_t upper_limit;

  logic [DW-1:0]  div_r;
  logic           tick;
  logic           cm_en_r;
  logic           config_done_r;
  logic           first_window_r;
  logic           halt_q_r;
  logic           idle_q_r;
  logic [7:0]     rdata_r;
  logic           oe_n_r;
  logic           cki_q_r;
  logic [CMW-1:0] cm_cnt_r;
  logic           cm_err_r;
  logic           cm_hold_r;
  logic           cm_done;
  logic           sv_done;
  logic           wr_hit;
  logic           accept_wr;
  logic           key_ok;
  logic           field_match;
  logic           early;
  logic           svc_ok;
  logic           wr_fault;
  logic           inhibit;
  logic           timeout;
  logic           halt_exit;
  logic           idle_exit;
  logic           sv_drive;
  logic           cm_drive;

  // ==========================================================
  // Instruction cycle enable
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      div_r <= '0;
    end else if (tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + DW'(1);
    end
  end

  assign tick = (div_r == DW'(INSTR_DIV - 1));

  // ==========================================================
  // Service decode
  assign wr_hit      = REG_WR_IN && (REG_ADDR_IN == `SWS_SVR_OFFSET);
  assign accept_wr   = wr_hit && (st_r == sws_pkg::SWS_RUN);
  assign key_ok      = (REG_WDATA_IN[`SWS_KEY_HI:`SWS_KEY_LO] == `SWS_KEY_VALUE);
  assign field_match = key_ok && (REG_WDATA_IN[`SWS_WIN_HI:`SWS_WIN_LO] == win_sel_r);
  // First window after reset has no lower bound
  assign early       = (cnt_r < `SWS_LOWER_LIMIT) && !first_window_r;
  assign svc_ok      = accept_wr && (config_done_r ? (field_match && !early) : key_ok);
  assign wr_fault    = accept_wr && !svc_ok;

  assign upper_limit = `SWS_UPPER_BASE << win_sel_r;
  assign inhibit     = HALT_MODE_IN || IDLE_MODE_IN;
  assign timeout     = (st_r == sws_pkg::SWS_RUN) && !inhibit && tick
                       && (cnt_r == (upper_limit - 17'h00001));
  assign halt_exit   = halt_q_r && !HALT_MODE_IN;
  assign idle_exit   = idle_q_r && !IDLE_MODE_IN;

  // ==========================================================
  // Settings, locked by the first keyed write
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      win_sel_r     <= `SWS_WIN_RESET;
      cm_en_r       <= `SWS_CM_RESET;
      config_done_r <= 1'b0;
    end else if (svc_ok && !config_done_r) begin
      win_sel_r     <= REG_WDATA_IN[`SWS_WIN_HI:`SWS_WIN_LO];
      cm_en_r       <= REG_WDATA_IN[`SWS_CM_BIT];
      config_done_r <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      first_window_r <= 1'b1;
    end else if (svc_ok || (st_r != sws_pkg::SWS_RUN)) begin
      first_window_r <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      halt_q_r <= 1'b0;
      idle_q_r <= 1'b0;
    end else begin
      halt_q_r <= HALT_MODE_IN;
      idle_q_r <= IDLE_MODE_IN;
    end
  end

  // ==========================================================
  // Window counter
  always_comb begin
    cnt_nxt = cnt_r;
    if (st_r != sws_pkg::SWS_RUN) begin
      cnt_nxt = '0;
    end else if (svc_ok || idle_exit) begin
      cnt_nxt = '0;
    end else if (halt_exit && (XTAL_OPTION_IN || CLOCK_DELAY_SELECT_IN)) begin
      cnt_nxt = '0;
    end else if (!inhibit && tick) begin
      cnt_nxt = cnt_r + 17'h00001;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // Fault sequencer
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      sws_pkg::SWS_RUN: begin
        if (wr_fault || timeout) begin
          st_nxt = sws_pkg::SWS_PULL;
        end
      end
      sws_pkg::SWS_PULL: begin
        if (!SUPERVISION_FAULT_PIN_IN) begin
          st_nxt = sws_pkg::SWS_HOLD;
        end
      end
      sws_pkg::SWS_HOLD: begin
        if (sv_done) begin
          st_nxt = sws_pkg::SWS_REARM;
        end
      end
      sws_pkg::SWS_REARM: begin
        if (SUPERVISION_FAULT_PIN_IN) begin
          st_nxt = sws_pkg::SWS_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      st_r <= sws_pkg::SWS_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Extra tick margin so the hold never falls under 16 full cycles
  sws_release_timer #(
    .COUNT    (RELEASE_CYC)
  ) u_sv_release (
    .clk_in   (SYS_CLK_IN),
    .rst_n_in (RESETN_IN),
    .run_in   (st_r == sws_pkg::SWS_HOLD),
    .tick_in  (tick),
    .done_out (sv_done)
  );

  // ==========================================================
  // Clock monitor, never gated by halt or idle
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cki_q_r  <= 1'b0;
      cm_cnt_r <= '0;
      cm_err_r <= 1'b0;
    end else begin
      cki_q_r <= CLOCK_INPUT_PIN_IN;
      if (CLOCK_INPUT_PIN_IN && !cki_q_r) begin
        cm_cnt_r <= '0;
      end else if (cm_cnt_r != CMW'(CM_LIMIT_CYC)) begin
        cm_cnt_r <= cm_cnt_r + CMW'(1);
      end
      // Limit sits between a 10 us and a 10 ms input period
      cm_err_r <= (cm_cnt_r == CMW'(CM_LIMIT_CYC));
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cm_hold_r <= 1'b0;
    end else if (cm_err_r) begin
      cm_hold_r <= 1'b1;
    end else if (cm_done) begin
      cm_hold_r <= 1'b0;
    end
  end

  sws_release_timer #(
    .COUNT    (RELEASE_CYC)
  ) u_cm_release (
    .clk_in   (SYS_CLK_IN),
    .rst_n_in (RESETN_IN),
    .run_in   (cm_hold_r && !cm_err_r),
    .tick_in  (tick),
    .done_out (cm_done)
  );

  // ==========================================================
  // Fault pin
  assign sv_drive = (st_r == sws_pkg::SWS_PULL) || (st_r == sws_pkg::SWS_HOLD);
  assign cm_drive = cm_en_r && (cm_err_r || cm_hold_r);

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= !(sv_drive || cm_drive);
    end
  end

  assign SUPERVISION_FAULT_PIN_OUT      = 1'b0;
  assign SUPERVISION_FAULT_PIN_OE_N_OUT = oe_n_r;

  // ==========================================================
  // Register read
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rdata_r <= 8'h00;
    end else if (REG_RD_IN) begin
      if (REG_ADDR_IN == `SWS_SVR_OFFSET) begin
        rdata_r <= {win_sel_r, 5'h00, cm_en_r};
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  assign REG_RDATA_OUT = rdata_r;

  // ==========================================================
  // Checks
  a_read_key_zero: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    REG_RD_IN && (REG_ADDR_IN == `SWS_SVR_OFFSET) |=> (REG_RDATA_OUT[5:1] == 5'h00))
    else $error("Key bits read back nonzero");

  a_settings_locked: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    config_done_r |=> $stable(win_sel_r) && $stable(cm_en_r))
    else $error("Settings changed after lock");

  a_reset_defaults: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    !config_done_r |-> (win_sel_r == 2'h3) && cm_en_r)
    else $error("Defaults lost before first write");

  a_timeout_fault: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    (st_r == sws_pkg::SWS_RUN) && !inhibit && tick && (cnt_r == upper_limit - 17'h00001)
    |=> (st_r == sws_pkg::SWS_PULL) ##1 !SUPERVISION_FAULT_PIN_OE_N_OUT)
    else $error("Upper limit did not fault");

  a_early_fault: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    accept_wr && config_done_r && (cnt_r < 17'h00800) && !first_window_r
    |=> (st_r == sws_pkg::SWS_PULL))
    else $error("Early service not faulted");

  a_mismatch_fault: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    accept_wr && config_done_r && (REG_WDATA_IN[7:1] != {win_sel_r, 5'h0C})
    |=> (st_r == sws_pkg::SWS_PULL) && $stable(win_sel_r))
    else $error("Mismatched service not faulted");

  a_ignore_in_fault: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    wr_hit && (st_r != sws_pkg::SWS_RUN) |=> $stable(config_done_r) && (cnt_r == 17'h00000))
    else $error("Write acted during fault");

  a_restart_high: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    (st_r == sws_pkg::SWS_REARM) && SUPERVISION_FAULT_PIN_IN
    |=> (st_r == sws_pkg::SWS_RUN) && (cnt_r == 17'h00000))
    else $error("Window not restarted on pin high");

  a_cm_drives_pin: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    cm_en_r && cm_err_r |=> !SUPERVISION_FAULT_PIN_OE_N_OUT)
    else $error("Clock error not on pin");

  a_halt_freeze: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    (st_r == sws_pkg::SWS_RUN) && HALT_MODE_IN && halt_q_r && !svc_ok
    |=> (cnt_r == $past(cnt_r)))
    else $error("Counter ran in halt");

  a_idle_exit_service: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    (st_r == sws_pkg::SWS_RUN) && idle_q_r && !IDLE_MODE_IN |=> (cnt_r == 17'h00000))
    else $error("Idle exit did not service");

endmodule

/* tb_top.sv */
// Self-checking bench for the service window supervisor top level
// Assumes sws_top with shortened counts; the fault pin is resolved here with a pull-up
`timescale 1ns/100ps

module tb_top;
  localparam int DIV = 4;
  localparam int CML = 200;
  localparam int RC  = 3;

  typedef struct {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] exp_rd;
  } sws_row_s;

  logic       sys_clk;
  logic       resetn;
  logic [7:0] addr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       halt;
  logic       idle;
  logic       ck_pin = 1'b0;
  logic       ck_run;
  logic       xtal;
  logic       clk_dly;
  logic       pin_out;
  logic       oe_n;
  wire        fault_pin;
  int         num_errors;
  int         compares;
  int         n;
  sws_row_s   rows [5];

  // Pull-up wins unless the block pulls the pin
  assign fault_pin = (oe_n === 1'b0) ? pin_out : 1'b1;

  sws_top #(.INSTR_DIV(DIV), .CM_LIMIT_CYC(CML), .RELEASE_CYC(RC)) u_dut (
    .SYS_CLK_IN                     (sys_clk),
    .RESETN_IN                      (resetn),
    .REG_ADDR_IN                    (addr),
    .REG_WR_IN                      (wr),
    .REG_RD_IN                      (rd),
    .REG_WDATA_IN                   (wdata),
    .REG_RDATA_OUT                  (rdata),
    .HALT_MODE_IN                   (halt),
    .IDLE_MODE_IN                   (idle),
    .XTAL_OPTION_IN                 (xtal),
    .CLOCK_DELAY_SELECT_IN          (clk_dly),
    .CLOCK_INPUT_PIN_IN             (ck_pin),
    .SUPERVISION_FAULT_PIN_IN       (fault_pin),
    .SUPERVISION_FAULT_PIN_OUT      (pin_out),
    .SUPERVISION_FAULT_PIN_OE_N_OUT (oe_n)
  );

  // ==========================================================
  // Clocks
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Monitored clock well above the monitor limit; freezes when ck_run drops
  always begin
    repeat (10) @(negedge sys_clk);
    if (ck_run) begin
      ck_pin = ~ck_pin;
    end
  end

  // ==========================================================
  // Tasks
  task automatic end_of_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_oe(input logic lvl, input int max, output int cnt);
    cnt = 0;
    while (oe_n !== lvl) begin
      @(negedge sys_clk);
      cnt++;
      if (cnt >= max) begin
        num_errors++;
        $display("FAIL wait for fault enable %b", lvl);
        end_of_test();
      end
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    wr    = 1'b1;
    addr  = a;
    wdata = d;
    @(negedge sys_clk);
    wr    = 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    rd   = 1'b1;
    addr = a;
    @(negedge sys_clk);
    rd   = 1'b0;
    @(negedge sys_clk);
    d    = rdata;
  endtask

  task automatic quiet(input int cycles);
    repeat (cycles) begin
      @(negedge sys_clk);
      check("fault enable quiet", oe_n, 1'b1);
    end
  endtask

  // Whole supervision pulse: pull, hold after pin low, release, rearm
  task automatic fault_pulse();
    int w;
    wait_oe(1'b0, 8, w);
    check("fault drive value", pin_out, 1'b0);
    wait_oe(1'b1, 200, w);
    check("fault low width", (w >= (RC - 1) * DIV) && (w <= (RC + 1) * DIV + 4), 1'b1);
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic do_reset();
    @(negedge sys_clk);
    resetn = 1'b0;
    repeat (3) @(negedge sys_clk);
    check("enable in reset", oe_n, 1'b1);
    check("rdata in reset", rdata, 8'h00);
    resetn = 1'b1;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] d;
    resetn = 1'b0;
    addr   = 8'h00;
    wr     = 1'b0;
    rd     = 1'b0;
    wdata  = 8'h00;
    halt   = 1'b0;
    idle   = 1'b0;
    ck_run = 1'b1;
    xtal   = 1'b1;
    clk_dly = 1'b0;
    num_errors = 0;
    compares   = 0;
    rows[0] = '{1'b0, 8'hC7, 8'h00, 8'hC1};
    rows[1] = '{1'b0, 8'h00, 8'h00, 8'h00};
    rows[2] = '{1'b0, 8'hC8, 8'h00, 8'h00};
    rows[3] = '{1'b1, 8'hC6, 8'h00, 8'hC1};
    rows[4] = '{1'b1, 8'hC8, 8'h18, 8'hC1};
    repeat (3) @(negedge sys_clk);
    resetn = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        reg_write(rows[i].addr, rows[i].data);
        reg_read(8'hC7, d);
      end else begin
        reg_read(rows[i].addr, d);
      end
      check("row read", d, rows[i].exp_rd);
      quiet(2);
    end
    // Early first keyed write: locks window 00, monitor off
    reg_write(8'hC7, 8'h18);
    quiet(20);
    reg_read(8'hC7, d);
    check("locked settings", d, 8'h00);
    ck_run = 1'b0;
    quiet(3 * CML);
    ck_run = 1'b1;
    repeat (2048 * DIV + 20) @(negedge sys_clk);
    reg_write(8'hC7, 8'h58);
    reg_write(8'hC7, 8'h58);
    fault_pulse();
    reg_read(8'hC7, d);
    check("settings kept", d, 8'h00);
    repeat (2048 * DIV + 20) @(negedge sys_clk);
    reg_write(8'hC7, 8'h18);
    quiet(20);
    reg_write(8'hC7, 8'h18);
    fault_pulse();
    // Upper limit of window 00 with no service
    wait_oe(1'b0, 9000 * DIV, n);
    check("timeout cycles", (n >= 8192 * DIV - 16) && (n <= 8192 * DIV + 8), 1'b1);
    fault_pulse();
    // Second reset in mid-run; monitor stays on this time
    do_reset();
    // Wrong key on the first write faults and locks nothing
    reg_write(8'hC7, 8'h1B);
    fault_pulse();
    reg_read(8'hC7, d);
    check("bad key not locked", d, 8'hC1);
    reg_write(8'hC7, 8'h19);
    repeat (2100 * DIV) @(negedge sys_clk);
    idle = 1'b1;
    repeat (2 * DIV) @(negedge sys_clk);
    idle = 1'b0;
    reg_write(8'hC7, 8'h18);
    fault_pulse();
    // Halt with a stopped clock pin is a monitor error
    halt   = 1'b1;
    ck_run = 1'b0;
    wait_oe(1'b0, CML + 50, n);
    check("monitor detect", (n >= CML - 20) && (n <= CML + 8), 1'b1);
    ck_run = 1'b1;
    wait_oe(1'b1, 300, n);
    check("monitor release", (n >= (RC - 1) * DIV) && (n <= (RC + 1) * DIV + 30), 1'b1);
    halt = 1'b0;
    quiet(20);
    // RC option, delay clear: count survives a short halt, service is valid
    xtal = 1'b0;
    repeat (2100 * DIV) @(negedge sys_clk);
    halt = 1'b1;
    repeat (8) @(negedge sys_clk);
    halt = 1'b0;
    reg_write(8'hC7, 8'h19);
    quiet(20);
    // RC option, delay set: window restarts, so a prompt service is early
    clk_dly = 1'b1;
    repeat (2100 * DIV) @(negedge sys_clk);
    halt = 1'b1;
    repeat (8) @(negedge sys_clk);
    halt = 1'b0;
    reg_write(8'hC7, 8'h19);
    fault_pulse();
    end_of_test();
  end
endmodule
